/* verilog/adm_pkg.sv */
// Constants, offsets and state codes of the audio DMA block with page mapping.
// Shared by the top module, the channel FIFO and the translation unit.
package adm_pkg;
  localparam int ADM_NCH = 4;
  localparam int ADM_FIFO_DWORDS = 24;
  localparam int ADM_MMU_CLIENTS = 8;
  localparam int ADM_AW = 12;
  // Register map, channel order: capture 1, playback 1, capture 2, playback 2
  localparam logic [11:0] ADM_OFS_BASE [4] = '{12'h094, 12'h0a0, 12'h0ac, 12'h0b8};
  localparam logic [11:0] ADM_OFS_PROT [4] = '{12'h098, 12'h0a4, 12'h0b0, 12'h0bc};
  localparam logic [11:0] ADM_OFS_PAGE [4] = '{12'h09c, 12'h0a8, 12'h0b4, 12'h0c0};
  localparam logic [11:0] ADM_OFS_PTR [4] = '{12'h0d0, 12'h0d4, 12'h0d8, 12'h0dc};
  localparam logic [11:0] ADM_OFS_ENABLE = 12'h0c4;
  localparam logic [11:0] ADM_OFS_STATUS = 12'h0c8;
  localparam logic [31:0] ADM_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] ADM_BASE_WMASK = 32'hffff_fffc;
  localparam logic [31:0] ADM_PROT_WMASK = 32'hffff_fffc;
  localparam logic [31:0] ADM_PAGE_WMASK = 32'hffff_f8f8;
  // Field positions of the page and control register
  localparam int ADM_PG_LSB = 12;
  localparam int ADM_MAP_EN_BIT = 11;
  localparam int ADM_LIMIT_MSB = 7;
  localparam int ADM_LIMIT_LSB = 4;
  localparam int ADM_PV_BIT = 3;
  // Status word: enables 3:0, drain 7:4, overflow 11:8, underflow 15:12, translation ok 19:16
  localparam int ADM_ST_OVF = 8;
  localparam int ADM_ST_UDF = 12;
  // Channels that fetch from memory
  localparam logic [3:0] ADM_CH_FETCH = 4'b0101;
  localparam logic [4:0] ADM_RANGE_SHIFT0 = 5'h05;
  localparam logic [31:0] ADM_DWORD_BYTES = 32'h0000_0004;
  localparam logic [1:0] ADM_PTE_BURST = 2'h2;
  localparam logic [1:0] ADM_DATA_BURST = 2'h1;
  typedef enum logic [2:0] {
    ADM_S_IDLE = 3'b001,
    ADM_S_PTE = 3'b010,
    ADM_S_DATA = 3'b100
  } adm_state_t;
endpackage

/* verilog/adm_fifo.sv */
// Dword FIFO of one audio channel, storage in flip-flops.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module adm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = adm_pkg::ADM_FIFO_DWORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  output logic full,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic empty
);
  import adm_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  if (DEPTH < 2) begin : g_bad_depth
    $error("adm_fifo: DEPTH must be at least 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [IW-1:0] wr_reg;
  logic [IW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  wire do_push = push & ~full & ~flush;
  wire do_pop = pop & ~empty & ~flush;
  wire [IW-1:0] wr_inc = (wr_reg == IW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
  wire [IW-1:0] rd_inc = (rd_reg == IW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
  assign full = cnt_reg == CW'(DEPTH);
  assign empty = cnt_reg == '0;
  assign rdata = mem_reg[rd_reg];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) wr_reg <= wr_inc;
      if (do_pop) rd_reg <= rd_inc;
      cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
    end
  end
  // Storage needs no reset; the count says what is valid
  always_ff @(posedge clk) begin
    if (do_push) mem_reg[wr_reg] <= wdata;
  end
endmodule

/* verilog/adm_mmu.sv */
// Page translation unit: current and prefetched page per client channel.
// Assumes the owner fetches two-Dword table bursts and reports each word.
`timescale 1ns/1ps
module adm_mmu #(
  parameter int N_CH = adm_pkg::ADM_MMU_CLIENTS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Client channels
  input wire logic [31:0] lin_addr [N_CH],
  input wire logic [19:0] pt_base [N_CH],
  input wire logic [N_CH-1:0] map_en,
  input wire logic [N_CH-1:0] flush_map,
  output logic [31:0] phys_addr [N_CH],
  output logic [N_CH-1:0] xlat_ok,
  // Table fetch
  output logic fetch_need,
  output logic [31:0] fetch_addr,
  input wire logic fetch_start,
  input wire logic fill_valid,
  input wire logic fill_idx,
  input wire logic [31:0] fill_data
);
  import adm_pkg::*;
  localparam int CH_W = (N_CH > 1) ? $clog2(N_CH) : 1;
  if (N_CH < 1 || N_CH > ADM_MMU_CLIENTS) begin : g_bad_nch
    $error("adm_mmu: N_CH out of range");
  end
  logic [19:0] cur_pg_reg [N_CH];
  logic [19:0] cur_tag_reg [N_CH];
  logic [19:0] nxt_pg_reg [N_CH];
  logic [19:0] nxt_tag_reg [N_CH];
  logic cur_v_reg [N_CH];
  logic nxt_v_reg [N_CH];
  logic [19:0] want_vpn [N_CH];
  logic [N_CH-1:0] miss;
  logic [N_CH-1:0] pre;
  logic [CH_W-1:0] sel_ch;
  logic sel_found;
  logic [CH_W-1:0] f_ch_reg;
  logic f_pre_reg;
  logic [19:0] f_vpn_reg;
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    wire [19:0] vpn = lin_addr[i][31:12];
    wire cur_hit = cur_v_reg[i] & (cur_tag_reg[i] == vpn);
    wire nxt_hit = nxt_v_reg[i] & (nxt_tag_reg[i] == vpn);
    wire nxt_ahead = nxt_v_reg[i] & (nxt_tag_reg[i] == vpn + 20'h0_0001);
    wire fill_me = fill_valid & (f_ch_reg == CH_W'(i));
    // A page crossing drops the hit and holds the channel back
    assign xlat_ok[i] = ~map_en[i] | cur_hit; // RL20 RL22
    assign phys_addr[i] = map_en[i] ? {cur_pg_reg[i], lin_addr[i][11:0]} : lin_addr[i]; // RL21 RL15
    assign miss[i] = map_en[i] & ~cur_hit & ~nxt_hit;
    assign pre[i] = map_en[i] & cur_hit & ~nxt_ahead; // RL23
    assign want_vpn[i] = miss[i] ? vpn : vpn + 20'h0_0001;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cur_pg_reg[i] <= '0;
        cur_tag_reg[i] <= '0;
        nxt_pg_reg[i] <= '0;
        nxt_tag_reg[i] <= '0;
        cur_v_reg[i] <= 1'b0;
        nxt_v_reg[i] <= 1'b0;
      end else if (flush_map[i] | ~map_en[i]) begin
        cur_v_reg[i] <= 1'b0;
        nxt_v_reg[i] <= 1'b0;
      end else if (fill_me & ~f_pre_reg & ~fill_idx) begin
        cur_pg_reg[i] <= fill_data[31:ADM_PG_LSB]; // RL17
        cur_tag_reg[i] <= f_vpn_reg;
        cur_v_reg[i] <= 1'b1;
      end else if (fill_me & (f_pre_reg ^ fill_idx)) begin
        nxt_pg_reg[i] <= fill_data[31:ADM_PG_LSB];
        nxt_tag_reg[i] <= f_vpn_reg + {19'h0_0000, fill_idx};
        nxt_v_reg[i] <= 1'b1;
      end else if (~cur_hit & nxt_hit) begin
        // Prefetched page becomes current the cycle after the pointer crosses
        cur_pg_reg[i] <= nxt_pg_reg[i];
        cur_tag_reg[i] <= nxt_tag_reg[i];
        cur_v_reg[i] <= 1'b1;
        nxt_v_reg[i] <= 1'b0;
      end
    end
  end
  // Misses take precedence over prefetches, lowest channel first
  always_comb begin
    sel_ch = '0;
    sel_found = 1'b0;
    for (int i = 0; i < N_CH; i++) begin
      if (!sel_found && miss[i]) begin
        sel_ch = CH_W'(i);
        sel_found = 1'b1;
      end
    end
    for (int i = 0; i < N_CH; i++) begin
      if (!sel_found && pre[i]) begin
        sel_ch = CH_W'(i);
        sel_found = 1'b1;
      end
    end
  end
  assign fetch_need = sel_found;
  // Ten index bits: one table page covers 4 Mbytes
  assign fetch_addr = {pt_base[sel_ch], want_vpn[sel_ch][9:0], 2'b00}; // RL25 RL18
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_ch_reg <= '0;
      f_pre_reg <= 1'b0;
      f_vpn_reg <= '0;
    end else if (fetch_start) begin
      f_ch_reg <= sel_ch;
      f_pre_reg <= ~miss[sel_ch];
      f_vpn_reg <= want_vpn[sel_ch];
    end
  end
endmodule

/* verilog/adm_audio_dma.sv */
// Audio DMA control with page mapping: four channels, APB registers,
// one system memory master port shared by table fetches and data.
// Contract
// [RL1] Four channels, each with a 24-Dword FIFO
// [RL2] Captures fetch from memory, playbacks store
// [RL3] One linear base address, no pitch
// [RL4] Overflow and underflow handled as video
// [RL5] Overflow locks input, address keeps advancing
// [RL6] Zero limit, zero mode: restart immediately
// [RL7] Zero limit, zero mode: no interrupt
// [RL8] Violation mode: lock, drain, clear enable
// [RL9] Nonzero limit: event on range boundary
// [RL10] Range is two to five-plus-limit bytes
// [RL11] Enabled channel starts at once
// [RL12] Base is byte address, low bits zero
// [RL13] Protection address bits 31..2 upper limit
// [RL14] Page base 31..12, mapping enable bit 11
// [RL15] Four-kbyte pages, bypass when unmapped
// [RL16] Host allocates aligned data and table pages
// [RL17] Host fills table entries, low bits zero
// [RL18] One table page bounds buffer to 4 Mbytes
// [RL19] Unit serves eight channels, own base each; the instance here is built with four
// [RL20] Fetch table entry before arbiter request
// [RL21] Upper 20 address bits from page entry
// [RL22] Page crossing stops channel until renewed
// [RL23] Always prefetch the next page entry
// [RL24] Table fetches are two-Dword bursts
// [RL25] Entry address is base plus four times page
// Assumes stream and memory partners run on clk.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module adm_audio_dma #(
  parameter int FIFO_DWORDS = adm_pkg::ADM_FIFO_DWORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB register slave
  input wire logic [adm_pkg::ADM_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System memory master, one Dword per acknowledge
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_len,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Capture streams, fed from memory
  input wire logic [1:0] cap_pop,
  output logic [31:0] cap_data [2],
  output logic [1:0] cap_valid,
  // Playback streams, stored to memory
  input wire logic [1:0] pbk_push,
  input wire logic [31:0] pbk_data [2],
  // Channel events, one-cycle pulses
  output logic [3:0] range_irq,
  output logic [3:0] protect_irq
);
  import adm_pkg::*;

  if (FIFO_DWORDS < 2) begin : g_bad_depth
    $error("adm_audio_dma: FIFO_DWORDS must be at least 2");
  end

  // Software registers
  logic [31:0] base_reg [ADM_NCH];
  logic [31:0] prot_reg [ADM_NCH];
  logic [31:0] page_reg [ADM_NCH];
  logic [31:0] ptr_reg [ADM_NCH];
  logic ten_reg [ADM_NCH];
  logic drain_reg [ADM_NCH];
  logic ovf_reg [ADM_NCH];
  logic udf_reg [ADM_NCH];
  logic rirq_reg [ADM_NCH];
  logic pirq_reg [ADM_NCH];

  // Bus and memory port flops
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  adm_state_t state_reg;
  logic [1:0] rr_reg;
  logic [1:0] cur_ch_reg;
  logic beat_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [31:0] mem_addr_reg;
  logic [1:0] mem_len_reg;
  logic [31:0] mem_wdata_reg;
  logic [31:0] cap_data_reg [2];
  logic cap_valid_reg [2];

  // Per-channel wiring
  logic f_full [ADM_NCH];
  logic f_empty [ADM_NCH];
  logic f_push [ADM_NCH];
  logic f_pop [ADM_NCH];
  logic f_flush [ADM_NCH];
  logic [31:0] f_wdata [ADM_NCH];
  logic [31:0] f_rdata [ADM_NCH];
  logic [31:0] phys [ADM_NCH];
  logic [19:0] pt_base [ADM_NCH];
  logic hit_base [ADM_NCH];
  logic hit_prot [ADM_NCH];
  logic hit_page [ADM_NCH];
  logic hit_ptr [ADM_NCH];
  logic ovf_evt [ADM_NCH];
  logic udf_evt [ADM_NCH];
  logic [31:0] rd_acc [ADM_NCH+1];
  wire [ADM_NCH-1:0] map_en;
  wire [ADM_NCH-1:0] flush_map;
  wire [ADM_NCH-1:0] xlat_ok;
  wire [ADM_NCH-1:0] elig;
  wire [ADM_NCH-1:0] ack;
  wire [ADM_NCH-1:0] hit_any;
  wire [3:0] ten_v;
  wire [3:0] drain_v;
  wire [3:0] ovf_v;
  wire [3:0] udf_v;

  // Translation unit handshake
  wire mmu_need;
  wire [31:0] mmu_addr;
  wire mmu_start;
  wire mmu_fill;

  // Channel pick
  logic [1:0] pick;
  logic pick_ok;
  logic [1:0] scan_idx;

  // APB decode and read selection
  wire apb_acc = psel & penable & pready_reg;
  wire apb_wr = apb_acc & pwrite;
  wire apb_setup = psel & ~penable;
  wire hit_en = paddr == ADM_OFS_ENABLE;
  wire hit_st = paddr == ADM_OFS_STATUS;
  wire mapped = (|hit_any) | hit_en | hit_st;
  wire st_w1c = apb_wr & hit_st;
  wire [31:0] st_word = {12'h000, xlat_ok, udf_v, ovf_v, drain_v, ten_v};
  wire [31:0] rd_mux = rd_acc[ADM_NCH]
                     | (hit_en ? {28'h000_0000, ten_v} : 32'h0000_0000)
                     | (hit_st ? st_word : 32'h0000_0000);

  assign rd_acc[0] = 32'h0000_0000;
  assign mmu_start = (state_reg == ADM_S_IDLE) & mmu_need;
  assign mmu_fill = (state_reg == ADM_S_PTE) & mem_ack;

  for (genvar k = 0; k < ADM_NCH; k++) begin : g_ch
    localparam bit FETCH = ADM_CH_FETCH[k];
    localparam int S = k / 2;
    wire [3:0] limit = page_reg[k][ADM_LIMIT_MSB:ADM_LIMIT_LSB];
    wire pv = page_reg[k][ADM_PV_BIT];
    wire [31:0] nxt_ptr = ptr_reg[k] + ADM_DWORD_BYTES;
    wire prot_hit = nxt_ptr[31:2] >= prot_reg[k][31:2]; // RL13
    wire [4:0] rexp = ADM_RANGE_SHIFT0 + {1'b0, limit}; // RL10
    wire [31:0] rmask = (32'h0000_0001 << rexp) - 32'h0000_0001;
    wire crossed = (limit != 4'h0) & ((nxt_ptr & rmask) == 32'h0000_0000); // RL9
    wire quiet = (limit == 4'h0) & ~pv;
    wire drained = drain_reg[k] & f_empty[k];

    assign hit_base[k] = paddr == ADM_OFS_BASE[k];
    assign hit_prot[k] = paddr == ADM_OFS_PROT[k];
    assign hit_page[k] = paddr == ADM_OFS_PAGE[k];
    assign hit_ptr[k] = paddr == ADM_OFS_PTR[k];
    assign hit_any[k] = hit_base[k] | hit_prot[k] | hit_page[k] | hit_ptr[k];
    assign rd_acc[k+1] = rd_acc[k]
                       | (hit_base[k] ? base_reg[k] : 32'h0000_0000)
                       | (hit_prot[k] ? prot_reg[k] : 32'h0000_0000)
                       | (hit_page[k] ? page_reg[k] : 32'h0000_0000)
                       | (hit_ptr[k] ? ptr_reg[k] : 32'h0000_0000);
    assign ten_v[k] = ten_reg[k];
    assign drain_v[k] = drain_reg[k];
    assign ovf_v[k] = ovf_reg[k];
    assign udf_v[k] = udf_reg[k];

    // Table fetches run only for channels that are switched on
    assign map_en[k] = page_reg[k][ADM_MAP_EN_BIT] & ten_reg[k]; // RL14
    assign pt_base[k] = page_reg[k][31:ADM_PG_LSB];
    assign flush_map[k] = apb_wr & hit_page[k];
    assign ack[k] = mem_ack & (state_reg == ADM_S_DATA) & (cur_ch_reg == 2'(k));
    // A disabled channel keeps its FIFO in reset
    assign f_flush[k] = ~ten_reg[k] | drain_reg[k]; // RL8
    assign elig[k] = ten_reg[k] & ~drain_reg[k] & xlat_ok[k]
                   & (FETCH ? ~f_full[k] : ~f_empty[k]); // RL20

    adm_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DWORDS)
    ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(f_flush[k]),
      .push(f_push[k]),
      .wdata(f_wdata[k]),
      .full(f_full[k]),
      .pop(f_pop[k]),
      .rdata(f_rdata[k]),
      .empty(f_empty[k])
    ); // RL1

    if (FETCH) begin : g_fetch
      assign f_push[k] = ack[k]; // RL2
      assign f_wdata[k] = mem_rdata;
      assign f_pop[k] = cap_pop[S] & ~f_empty[k];
      assign ovf_evt[k] = 1'b0;
      // Reader gets no valid on an empty FIFO and simply retries
      assign udf_evt[k] = cap_pop[S] & f_empty[k]; // RL4
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cap_valid_reg[S] <= 1'b0;
          cap_data_reg[S] <= 32'h0000_0000;
        end else begin
          cap_valid_reg[S] <= f_pop[k];
          if (f_pop[k]) cap_data_reg[S] <= f_rdata[k];
        end
      end
    end else begin : g_store
      // Input locked while full, draining or disabled
      assign f_push[k] = pbk_push[S] & ~f_full[k] & ~f_flush[k]; // RL5 RL8
      assign f_wdata[k] = pbk_data[S];
      assign f_pop[k] = ack[k]; // RL2
      assign ovf_evt[k] = pbk_push[S] & f_full[k] & ten_reg[k] & ~drain_reg[k]; // RL4
      assign udf_evt[k] = 1'b0;
    end

    // Software registers, reserved bits held at zero
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        base_reg[k] <= ADM_REG_RESET;
        prot_reg[k] <= ADM_REG_RESET;
        page_reg[k] <= ADM_REG_RESET;
      end else if (apb_wr) begin
        if (hit_base[k]) base_reg[k] <= pwdata & ADM_BASE_WMASK; // RL12 RL3
        if (hit_prot[k]) prot_reg[k] <= pwdata & ADM_PROT_WMASK; // RL13
        if (hit_page[k]) page_reg[k] <= pwdata & ADM_PAGE_WMASK; // RL14
      end
    end

    // Pointer: parked on base while off, so enabling starts at once
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_reg[k] <= ADM_REG_RESET;
      end else if (!ten_reg[k]) begin
        ptr_reg[k] <= base_reg[k]; // RL11
      end else if (ack[k]) begin
        ptr_reg[k] <= (prot_hit & ~pv) ? base_reg[k] : nxt_ptr; // RL6
      end else if (ovf_evt[k]) begin
        // Dropped word still consumes its address and wraps like a stored one
        ptr_reg[k] <= (prot_hit & ~pv) ? base_reg[k] : nxt_ptr; // RL5 RL6
      end
    end

    // Enable and drain; a software write wins over the hardware clear
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ten_reg[k] <= 1'b0;
        drain_reg[k] <= 1'b0;
      end else begin
        if (apb_wr & hit_en) ten_reg[k] <= pwdata[k];
        else if (drained) ten_reg[k] <= 1'b0; // RL8
        if (ack[k] & prot_hit & pv) drain_reg[k] <= 1'b1; // RL8
        else if (f_empty[k]) drain_reg[k] <= 1'b0;
      end
    end

    // Sticky error flags: a new event wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ovf_reg[k] <= 1'b0;
        udf_reg[k] <= 1'b0;
      end else begin
        ovf_reg[k] <= ovf_evt[k] | (ovf_reg[k] & ~(st_w1c & pwdata[ADM_ST_OVF+k])); // RL4
        udf_reg[k] <= udf_evt[k] | (udf_reg[k] & ~(st_w1c & pwdata[ADM_ST_UDF+k])); // RL4
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rirq_reg[k] <= 1'b0;
        pirq_reg[k] <= 1'b0;
      end else begin
        rirq_reg[k] <= ack[k] & crossed; // RL9
        pirq_reg[k] <= ack[k] & prot_hit & ~quiet; // RL7
      end
    end

    assign range_irq[k] = rirq_reg[k];
    assign protect_irq[k] = pirq_reg[k];
  end

  // Four audio clients here; the unit is built with N_CH set to ADM_NCH, so it has four client ports
  adm_mmu #(
    .N_CH(ADM_NCH)
  ) u_mmu (
    .clk(clk),
    .rst_n(rst_n),
    .lin_addr(ptr_reg),
    .pt_base(pt_base),
    .map_en(map_en),
    .flush_map(flush_map),
    .phys_addr(phys),
    .xlat_ok(xlat_ok),
    .fetch_need(mmu_need),
    .fetch_addr(mmu_addr),
    .fetch_start(mmu_start),
    .fill_valid(mmu_fill),
    .fill_idx(beat_reg),
    .fill_data(mem_rdata)
  ); // RL19

  // Round robin over eligible channels, starting after the last served
  always_comb begin
    pick = rr_reg;
    pick_ok = 1'b0;
    scan_idx = rr_reg;
    for (int j = 0; j < ADM_NCH; j++) begin
      scan_idx = rr_reg + 2'(j);
      if (!pick_ok && elig[scan_idx]) begin
        pick = scan_idx;
        pick_ok = 1'b1;
      end
    end
  end

  // APB slave: data captured in setup, ready in the first access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup & ~mapped;
      if (apb_setup) prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Memory sequencer: table fetch has priority over channel data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ADM_S_IDLE;
      rr_reg <= 2'h0;
      cur_ch_reg <= 2'h0;
      beat_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 32'h0000_0000;
      mem_len_reg <= 2'h0;
      mem_wdata_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        ADM_S_IDLE: begin
          if (mmu_need) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= mmu_addr; // RL20
            mem_len_reg <= ADM_PTE_BURST; // RL24
            beat_reg <= 1'b0;
            state_reg <= ADM_S_PTE;
          end else if (pick_ok) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= ~ADM_CH_FETCH[pick]; // RL2
            mem_addr_reg <= phys[pick]; // RL21
            mem_wdata_reg <= f_rdata[pick];
            mem_len_reg <= ADM_DATA_BURST;
            cur_ch_reg <= pick;
            rr_reg <= pick + 2'h1;
            state_reg <= ADM_S_DATA;
          end
        end
        ADM_S_PTE: begin
          if (mem_ack) begin
            beat_reg <= 1'b1;
            if (beat_reg) begin
              mem_req_reg <= 1'b0;
              state_reg <= ADM_S_IDLE;
            end
          end
        end
        ADM_S_DATA: begin
          if (mem_ack) begin
            mem_req_reg <= 1'b0;
            state_reg <= ADM_S_IDLE;
          end
        end
        default: begin
          mem_req_reg <= 1'b0;
          state_reg <= ADM_S_IDLE;
        end
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_len = mem_len_reg;
  assign mem_wdata = mem_wdata_reg;
  assign cap_data = cap_data_reg;
  assign cap_valid = {cap_valid_reg[1], cap_valid_reg[0]};
endmodule

/* tb/adm_audio_dma_chk.sv */
// Port assertions for the audio DMA top module.
// Bound to every adm_audio_dma instance; one clock domain.
`timescale 1ns/1ps
module adm_audio_dma_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus, memory and events
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_len,
  input wire logic mem_ack,
  input wire logic [1:0] cap_pop,
  input wire logic [1:0] cap_valid,
  input wire logic [3:0] range_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  apb_wait_a: assert property (psel && !penable |=> pready) else $error("late pready");
  apb_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request moved");
  pte_burst_a: assert property (mem_req && mem_len != 1 |-> mem_len == 2 && !mem_we)
    else $error("bad burst");
  word_align_a: assert property (mem_req |-> mem_addr[1:0] == 0)
    else $error("unaligned");
  data_end_a: assert property (mem_ack && mem_len == 1 |=> !mem_req)
    else $error("request overran");
  pop_echo_a: assert property (cap_valid[0] |-> $past(cap_pop[0]))
    else $error("unasked data");
  range_beat_a: assert property (|range_irq |-> $past(mem_ack))
    else $error("range without beat");
endmodule
bind adm_audio_dma adm_audio_dma_chk u_adm_audio_dma_chk (.*);

/* tb/adm_mem_model.sv */
// System memory partner: one beat per acknowledge, at a random pace.
// Table page at 0x0001_0000; other reads return a scrambled address.
`timescale 1ns/1ps
module adm_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_len,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  int seed = 88380;
  logic g;
  logic [1:0] n, t;
  logic [31:0] a;
  assign t = n + {1'b0, mem_ack};
  assign a = mem_addr + {28'h000_0000, t, 2'b00};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {mem_ack, n, mem_rdata} <= 0;
    end else begin
      // Random stalls, never a beat past the last
      g = mem_req && t != mem_len && ($random(seed) & 3) != 0;
      n <= t == mem_len ? 2'b00 : t;
      mem_ack <= g;
      // Idle data lines show the inverse, not a stale copy
      mem_rdata <= !g ? ~mem_rdata : a[31:12] == 20'h0_0010 ?
        {10'h000, a[11:2] ^ 10'h155, 12'h000} : a ^ 32'h5a5a_5a5a;
    end
  end
endmodule

/* tb/adm_audio_dma_bench.sv */
// Bench for the audio DMA block: APB set-up, stream traffic, memory checks.
// Memory partner answers at random pace; functions give expectations.
`timescale 1ns/1ps
module adm_audio_dma_bench;
  import adm_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, e, go, sn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, r, d, lin, mlin, pq[$];
  logic [1:0] mem_len, cap_pop, cap_valid, pbk_push;
  logic [31:0] cap_data [2], pbk_data [2];
  logic [3:0] range_irq, protect_irq;
  int seed = 88380, n_mismatch, checked, cyc, nr, np, er, ep, k;
  localparam logic [43:0] CFG [10] = '{{12'h094, 32'h0000_3fc0}, {12'h098, 32'h0000_4010},
    {12'h09c, 32'h0001_0810}, {12'h0a0, 32'h0008_0000}, {12'h0a4, 32'h0008_0020},
    {12'h0a8, 32'h0000_0008}, {12'h0b8, 32'h0009_0000}, {12'h0bc, 32'h0009_0040},
    {12'h0c0, 32'h0000_0000}, {12'h0c4, 32'h0000_000b}};
  adm_audio_dma u_adm_audio_dma (.*);
  adm_mem_model u_adm_mem_model (.*);
  function automatic logic [31:0] phys(input logic [31:0] l);
    return {10'h000, l[21:12] ^ 10'h155, l[11:0]};
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return l + 4 >= 32'h0000_4010 ? 32'h0000_3fc0 : l + 4;
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Entered after an edge; request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 0;
    @(posedge clk);
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cap_pop <= {1'b0, go & 1'($random(seed))};
    if (cap_valid[0]) begin
      chk("capture", phys(lin) ^ 32'h5a5a_5a5a, cap_data[0]);
      lin = nxt(lin);
    end
    if (mem_req && mem_len == 2) begin
      sn = 1;
      chk("table", 32'h0001_0000, {mem_addr[31:12], 12'h000});
    end
    if (mem_ack && !mem_we && mem_len == 1) begin
      chk("first", 1, sn);
      chk("read", phys(mlin), mem_addr);
      er += mlin[5:0] == 6'h3c;
      ep += mlin == 32'h0000_400c;
      mlin = nxt(mlin);
    end
    if (mem_ack && mem_we && !mem_addr[16]) begin
      chk("store", pq[k], mem_wdata);
      chk("store at", 32'h0008_0000 + 4 * k, mem_addr);
      k++;
    end
    if (mem_ack && mem_we && mem_addr[16]) chk("wrap", 26'h240_0000 >> 12, mem_addr[31:6]);
    if (protect_irq[3]) chk("silent", 0, 1);
    nr += range_irq[0];
    np += protect_irq[0];
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pbk_push, cap_pop, go, sn} = 0;
    pbk_data = '{32'h0000_0000, 32'h0000_0000};
    lin = 32'h0000_3fc0;
    mlin = lin;
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    @(posedge clk);
    for (int j = 0; j < 12; j++) begin
      d = $random(seed);
      apb(0, 12'h094 + 12'(4 * j), 0);
      chk("reset", 0, r);
      apb(1, 12'h094 + 12'(4 * j), d);
      apb(0, 12'h094 + 12'(4 * j), 0);
      chk("reg", d & (j % 3 == 2 ? 32'hffff_f8f8 : 32'hffff_fffc), r);
    end
    apb(1, 12'h0e0, 1);
    chk("unmapped", 1, e);
    foreach (CFG[i]) apb(1, CFG[i][43:32], CFG[i][31:0]);
    go <= 1;
    for (int i = 0; i < 60; i++) begin
      d = $random(seed);
      if (i < 12) pq.push_back(d);
      pbk_push <= i < 12 ? 2'b01 : 2'b10;
      pbk_data <= '{d, d};
      @(posedge clk);
    end
    pbk_push <= 0;
    while (nr < 3) @(posedge clk);
    go <= 0;
    repeat (300) @(posedge clk);
    apb(0, ADM_OFS_STATUS, 0);
    chk("status", 32'h0000_0809, r & 32'h0000_080f);
    apb(1, ADM_OFS_STATUS, 32'h0000_0800);
    apb(0, ADM_OFS_STATUS, 0);
    chk("cleared", 0, r[ADM_ST_OVF + 3]);
    apb(1, ADM_OFS_ENABLE, 0);
    chk("ranges", er, nr);
    chk("protects", ep, np);
    chk("stores", 8, k);
    stop_test();
  end
endmodule
